/* File: design/spe_pkg.sv */
// shared constants and types of the serial slave endpoint
package spe_pkg;

  localparam int CLK_PERIOD_NS = 20;
  localparam int REQUEST_PULSE_TIME_NS = 1000;
  localparam int POWER_ON_SETTLE_TIME_US = 10;
  localparam int READY_TIME_NS = 2000;
  localparam int RESUME_TIME_NS = 4000;
  localparam int MAX_CLK_KHZ = 25000;

  localparam int TIMER_W = 16;
  localparam int BYTE_W = 8;
  localparam int BIT_IDX_W = 3;
  localparam int READY_W = 16;

  // least times round up to whole cycles
  localparam int REQ_CYC_INT =
    (REQUEST_PULSE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POT_CYC_DEF =
    (POWER_ON_SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest time rounds down
  localparam int READY_CYC_INT = READY_TIME_NS / CLK_PERIOD_NS;

  localparam logic [TIMER_W-1:0] REQ_CYC = TIMER_W'(REQ_CYC_INT);
  // settle window after a self-driven select is released
  localparam logic [TIMER_W-1:0] RECONF_CYC = 16'h0004;
  localparam logic [TIMER_W-1:0] TIMER_MAX = 16'hffff;
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;
  localparam logic [BIT_IDX_W-1:0] BIT_LAST = 3'h7;
  localparam logic [BIT_IDX_W-1:0] BIT_ZERO = 3'h0;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    ST_INIT   = 3'h0,
    ST_DESEL  = 3'h1,
    ST_SEL    = 3'h3,
    ST_PROACT = 3'h2,
    ST_BUSY   = 3'h6,
    ST_SLEEP  = 3'h7
  } spe_state_t;

  typedef struct packed {
    logic [READY_W-1:0] max_clk_khz;
    logic [READY_W-1:0] ready_time_ns;
    logic [READY_W-1:0] resume_time_ns;
  } spe_readiness_parameters_t;

  typedef struct packed {
    logic [BYTE_W-1:0] data;
    logic valid;
  } spe_rx_t;

endpackage

/* File: design/spe_sync.sv */
// two-flop level synchroniser into the reference clock domain
`timescale 1ns/100ps
`default_nettype none
module spe_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end

  assign q = sync_r;

endmodule
`default_nettype wire

/* File: design/spe_link.sv */
// shifter on the serial clock: receives on rising, shifts out on falling
`timescale 1ns/100ps
`default_nettype none
module spe_link (
  input wire logic spi_clk,
  input wire logic link_clr,
  input wire logic link_init,
  input wire logic spi_mosi,
  input wire logic [spe_pkg::BYTE_W-1:0] tx_word,
  output logic spi_miso_o,
  output logic [spe_pkg::BYTE_W-1:0] rx_byte,
  output logic rx_toggle
);
  import spe_pkg::*;

  logic [BYTE_W-1:0] rx_shift_r;
  logic [BIT_IDX_W-1:0] rx_cnt_r;
  logic [BIT_IDX_W-1:0] tx_idx_r;
  logic [BYTE_W-1:0] rx_byte_r;
  logic rx_tgl_r;

  // frame state ends with the select line, no edge needed after the frame
  always_ff @(posedge spi_clk or posedge link_clr) begin
    if (link_clr) begin
      rx_shift_r <= BYTE_ZERO;
      rx_cnt_r <= BIT_ZERO;
    end else begin
      rx_shift_r <= {rx_shift_r[BYTE_W-2:0], spi_mosi};
      rx_cnt_r <= rx_cnt_r + 3'h1;
    end
  end

  // completed byte and its event toggle survive the frame end
  always_ff @(posedge spi_clk or posedge link_init) begin
    if (link_init) begin
      rx_byte_r <= BYTE_ZERO;
      rx_tgl_r <= 1'b0;
    end else if (rx_cnt_r == BIT_LAST) begin
      rx_byte_r <= {rx_shift_r[BYTE_W-2:0], spi_mosi};
      rx_tgl_r <= ~rx_tgl_r;
    end
  end

  // clock idles low, so the first bit is out before the first rise
  always_ff @(negedge spi_clk or posedge link_clr) begin
    if (link_clr) begin
      tx_idx_r <= BIT_ZERO;
    end else begin
      tx_idx_r <= tx_idx_r + 3'h1;
    end
  end

  assign spi_miso_o = tx_word[BIT_LAST - tx_idx_r];
  assign rx_byte = rx_byte_r;
  assign rx_toggle = rx_tgl_r;

endmodule
`default_nettype wire

/* File: design/spe_endpoint.sv */
// slave endpoint state machine with select handling and serial link
`timescale 1ns/100ps
`default_nettype none
module spe_endpoint #(
  parameter int POT_CYC = spe_pkg::POT_CYC_DEF,
  parameter int MAX_CLK_KHZ = spe_pkg::MAX_CLK_KHZ,
  parameter int READY_TIME_NS = spe_pkg::READY_TIME_NS,
  parameter int RESUME_TIME_NS = spe_pkg::RESUME_TIME_NS
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_clk,
  input wire logic spi_mosi,
  output logic spi_miso_o,
  output logic spi_miso_oe,
  input wire logic slave_select_n_i,
  output logic slave_select_n_o,
  output logic slave_select_n_oe,
  output logic spi_int_o,
  input wire logic four_wire,
  input wire logic tx_pending,
  input wire logic [spe_pkg::BYTE_W-1:0] tx_data,
  output logic req_sent,
  input wire logic busy_req,
  input wire logic sleep_req,
  output spe_pkg::spe_rx_t rx,
  output spe_pkg::spe_state_t slave_state,
  output spe_pkg::spe_readiness_parameters_t readiness_parameters
);
  import spe_pkg::*;

  localparam logic [TIMER_W-1:0] POT_LAST = TIMER_W'(POT_CYC - 1);
  // request pulse plus settle window must stay inside the ready time
  localparam logic [TIMER_W-1:0] READY_CYC = TIMER_W'(READY_CYC_INT);

  spe_state_t state_r;
  spe_state_t state_nxt;
  logic [TIMER_W-1:0] timer_r;
  logic [TIMER_W-1:0] guard_r;
  logic nss_drv_r;
  logic nss_drv_nxt;
  logic int_drv_r;
  logic int_drv_nxt;
  logic link_hold_r;
  logic link_init_r;
  logic miso_oe_r;
  logic [BYTE_W-1:0] tx_word_r;
  logic [BYTE_W-1:0] rx_data_r;
  logic rx_valid_r;
  logic rx_seen_r;
  logic req_sent_r;
  logic ss_n_s;
  logic rx_tgl_s;
  logic ss_low_s;
  logic master_low;
  logic line_idle;
  logic pulse_done;
  logic link_clr;
  logic link_miso;
  logic link_tgl;
  logic [BYTE_W-1:0] link_byte;

  spe_sync #(
    .WIDTH(2),
    .RST_VAL(2'h1)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d({link_tgl, slave_select_n_i}),
    .q({rx_tgl_s, ss_n_s})
  );

  assign ss_low_s = ~ss_n_s;
  // our own drive and its settle window are not a master select
  assign master_low = ss_low_s && !nss_drv_r && (guard_r == TIMER_ZERO);
  assign line_idle = !ss_low_s && !nss_drv_r && (guard_r == TIMER_ZERO);
  assign pulse_done = (timer_r > REQ_CYC) && !nss_drv_r && !int_drv_r;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_INIT: begin
        if (timer_r >= POT_LAST) begin
          state_nxt = ST_DESEL;
        end
      end
      ST_DESEL: begin
        if (master_low) begin
          state_nxt = ST_SEL;
        end else if (tx_pending && line_idle) begin
          state_nxt = ST_PROACT;
        end else if (sleep_req) begin
          state_nxt = ST_SLEEP;
        end
      end
      ST_SEL: begin
        if (!ss_low_s) begin
          state_nxt = ST_DESEL;
        end else if (busy_req && four_wire) begin
          state_nxt = ST_BUSY;
        end else if (tx_pending && !four_wire) begin
          state_nxt = ST_PROACT;
        end
      end
      ST_PROACT: begin
        if (pulse_done && (guard_r == TIMER_ZERO)) begin
          if (ss_low_s) begin
            state_nxt = ST_SEL;
          end else begin
            state_nxt = ST_DESEL;
          end
        end
      end
      ST_BUSY: begin
        if (!busy_req) begin
          state_nxt = ST_DESEL;
        end
      end
      ST_SLEEP: begin
        if (ss_low_s) begin
          state_nxt = ST_SEL;
        end
      end
      default: begin
        state_nxt = ST_INIT;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // cycles spent in the current state, saturating
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      timer_r <= TIMER_ZERO;
    end else if (state_nxt != state_r) begin
      timer_r <= TIMER_ZERO;
    end else if (timer_r != TIMER_MAX) begin
      timer_r <= timer_r + 16'h0001;
    end
  end

  // request pulses: exactly REQ_CYC cycles wide
  always_comb begin
    nss_drv_nxt = 1'b0;
    int_drv_nxt = 1'b0;
    if (state_r == ST_PROACT && timer_r < REQ_CYC) begin
      nss_drv_nxt = four_wire;
      int_drv_nxt = !four_wire;
    end
    if (state_r == ST_BUSY) begin
      nss_drv_nxt = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      nss_drv_r <= 1'b0;
      int_drv_r <= 1'b0;
    end else begin
      nss_drv_r <= nss_drv_nxt;
      int_drv_r <= int_drv_nxt;
    end
  end

  // after releasing select, wait until the synchroniser shows the line
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      guard_r <= TIMER_ZERO;
    end else if (nss_drv_r && !nss_drv_nxt) begin
      guard_r <= RECONF_CYC;
    end else if (guard_r != TIMER_ZERO) begin
      guard_r <= guard_r - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      req_sent_r <= 1'b0;
    end else begin
      req_sent_r <= (state_r == ST_PROACT) && (state_nxt != ST_PROACT);
    end
  end

  // link runs only when selected or in a five-wire request
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      link_hold_r <= 1'b1;
      link_init_r <= 1'b1;
      miso_oe_r <= 1'b0;
    end else begin
      link_hold_r <= !((state_r == ST_SEL) ||
        (state_r == ST_PROACT && !four_wire));
      link_init_r <= (state_r == ST_INIT);
      miso_oe_r <= (state_r == ST_SEL) ||
        (state_r == ST_PROACT && !four_wire && ss_low_s);
    end
  end

  // transmit byte is frozen while the link may be clocking
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_word_r <= BYTE_ZERO;
    end else if (link_hold_r) begin
      tx_word_r <= tx_data;
    end
  end

  // received byte event crosses as a toggle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx_seen_r <= 1'b0;
      rx_valid_r <= 1'b0;
      rx_data_r <= BYTE_ZERO;
    end else if (link_init_r) begin
      rx_seen_r <= 1'b0;
      rx_valid_r <= 1'b0;
    end else begin
      rx_seen_r <= rx_tgl_s;
      rx_valid_r <= (rx_tgl_s != rx_seen_r);
      if (rx_tgl_s != rx_seen_r) begin
        rx_data_r <= link_byte;
      end
    end
  end

  // de-selected: link held in clear, clock and data have no effect
  assign link_clr = link_hold_r | slave_select_n_i;

  spe_link u_link (
    .spi_clk(spi_clk),
    .link_clr(link_clr),
    .link_init(link_init_r),
    .spi_mosi(spi_mosi),
    .tx_word(tx_word_r),
    .spi_miso_o(link_miso),
    .rx_byte(link_byte),
    .rx_toggle(link_tgl)
  );

  assign spi_miso_o = link_miso;
  assign spi_miso_oe = miso_oe_r;
  assign slave_select_n_o = 1'b0;
  assign slave_select_n_oe = nss_drv_r;
  assign spi_int_o = int_drv_r;
  assign req_sent = req_sent_r;
  assign rx.data = rx_data_r;
  assign rx.valid = rx_valid_r;
  assign slave_state = state_r;
  assign readiness_parameters.max_clk_khz = READY_W'(MAX_CLK_KHZ);
  assign readiness_parameters.ready_time_ns = READY_W'(READY_TIME_NS);
  assign readiness_parameters.resume_time_ns = READY_W'(RESUME_TIME_NS);

endmodule
`default_nettype wire

/* File: verification/spe_endpoint_props.sv */
// port checker for the serial slave endpoint
`timescale 1ns/100ps
`default_nettype none
module spe_endpoint_props #(
  parameter int POT_CYC = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic spi_miso_oe,
  input wire logic slave_select_n_oe,
  input wire logic spi_int_o,
  input wire logic four_wire,
  input wire logic tx_pending,
  input wire logic req_sent,
  input var spe_pkg::spe_state_t slave_state
);
  import spe_pkg::*;
  int init_cnt_r;
  int int_cnt_r;
  int ss_cnt_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // cycles in init, widths of the two request pulses
  always_ff @(posedge ref_clk) begin
    init_cnt_r <= (rst_n && slave_state == ST_INIT) ? init_cnt_r + 1 : 0;
  end
  always_ff @(posedge ref_clk) begin
    int_cnt_r <= spi_int_o ? int_cnt_r + 1 : 0;
  end
  always_ff @(posedge ref_clk) begin
    ss_cnt_r <= slave_select_n_oe ? ss_cnt_r + 1 : 0;
  end
  property p_init_quiet;
    slave_state == ST_INIT |-> !spi_miso_oe && !slave_select_n_oe
      && !spi_int_o;
  endproperty
  a_init_quiet: assert property (p_init_quiet) else $error("init out");
  property p_pot_exit;
    $past(slave_state) == ST_INIT && slave_state != ST_INIT |->
      slave_state == ST_DESEL && init_cnt_r >= POT_CYC - 1
      && init_cnt_r <= POT_CYC + 3;
  endproperty
  a_pot_exit: assert property (p_pot_exit) else $error("init exit");
  property p_desel_float;
    slave_state == ST_DESEL && $past(slave_state) == ST_DESEL |-> !spi_miso_oe;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("miso on");
  property p_desel_next;
    $past(slave_state) == ST_DESEL && slave_state != ST_DESEL |->
      slave_state inside {ST_SEL, ST_PROACT, ST_SLEEP};
  endproperty
  a_desel_next: assert property (p_desel_next) else $error("desel exit");
  property p_sel_drive;
    slave_state == ST_SEL && $past(slave_state) == ST_SEL |-> spi_miso_oe;
  endproperty
  a_sel_drive: assert property (p_sel_drive) else $error("miso off");
  property p_sel_next;
    $past(slave_state) == ST_SEL && slave_state != ST_SEL |->
      slave_state inside {ST_DESEL, ST_PROACT, ST_BUSY};
  endproperty
  a_sel_next: assert property (p_sel_next) else $error("sel exit");
  property p_int_len;
    $fell(spi_int_o) |-> int_cnt_r == REQ_CYC_INT;
  endproperty
  a_int_len: assert property (p_int_len) else $error("int width");
  property p_ss_len;
    $fell(slave_select_n_oe) && slave_state == ST_PROACT |->
      ss_cnt_r == REQ_CYC_INT;
  endproperty
  a_ss_len: assert property (p_ss_len) else $error("ss width");
  property p_proact_in;
    slave_state == ST_PROACT && $past(slave_state) != ST_PROACT |->
      $past(tx_pending) && $past(slave_state) inside {ST_DESEL, ST_SEL};
  endproperty
  a_proact_in: assert property (p_proact_in) else $error("proact in");
  property p_proact_out;
    $past(slave_state) == ST_PROACT && slave_state != ST_PROACT |->
      slave_state inside {ST_DESEL, ST_SEL} ##[0:1] req_sent;
  endproperty
  a_proact_out: assert property (p_proact_out) else $error("proact out");
  property p_busy;
    slave_state == ST_BUSY |-> four_wire ##1
      slave_state inside {ST_BUSY, ST_DESEL};
  endproperty
  a_busy: assert property (p_busy) else $error("busy exit");
  property p_sleep;
    $past(slave_state) == ST_SLEEP && slave_state != ST_SLEEP |->
      slave_state == ST_SEL;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep exit");
  c_int: cover property (slave_state == ST_PROACT && spi_int_o);
  c_busy: cover property (slave_state == ST_BUSY);
  c_wake: cover property (slave_state == ST_SLEEP ##1 slave_state == ST_SEL);
endmodule
bind spe_endpoint spe_endpoint_props #(.POT_CYC(POT_CYC)) u_spe_endpoint_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .spi_miso_oe(spi_miso_oe),
  .slave_select_n_oe(slave_select_n_oe), .spi_int_o(spi_int_o),
  .four_wire(four_wire), .tx_pending(tx_pending), .req_sent(req_sent),
  .slave_state(slave_state)
);
`default_nettype wire

/* File: verification/spe_master_model.sv */
// behavioural serial master: clock, data out and its select
`timescale 1ns/100ps
`default_nettype none
module spe_master_model (
  output logic spi_clk,
  output logic spi_mosi,
  output logic sel_n,
  input wire logic spi_miso
);
  initial begin
    spi_clk = 1'b0;
    spi_mosi = 1'b0;
    sel_n = 1'b1;
  end
  // two bytes, msb first, 32 ns clock
  task automatic frame(input logic [15:0] mo, input int wait_ns,
    output logic [15:0] mi);
    sel_n = 1'b0;
    #(wait_ns);
    for (int i = 15; i >= 0; i--) begin
      spi_mosi = mo[i];
      #16 spi_clk = 1'b1;
      mi[i] = spi_miso;
      #16 spi_clk = 1'b0;
    end
    #16 sel_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask
  // clocks without select, to be ignored
  task automatic stray(input int n);
    repeat (n) begin
      spi_mosi = ~spi_mosi;
      #16 spi_clk = 1'b1;
      #16 spi_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/spe_endpoint_tb.sv */
// self-checking bench of the serial slave endpoint
`timescale 1ns/100ps
`default_nettype none
`define SPE_CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  errors++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module spe_endpoint_tb;
  import spe_pkg::*;
  localparam int MAX_KHZ = 31250;
  localparam logic [47:0] RDY = {16'(MAX_KHZ), 16'(READY_TIME_NS),
    16'(RESUME_TIME_NS)};
  logic ref_clk, rst_n, spi_clk, spi_mosi, spi_miso_o, spi_miso_oe, sel_n;
  logic slave_select_n_i, slave_select_n_o, slave_select_n_oe, spi_int_o;
  logic four_wire, tx_pending, req_sent, busy_req, sleep_req, miso_w;
  logic [7:0] tx_data, exp_b;
  logic [15:0] mi_b;
  spe_rx_t rx;
  spe_state_t slave_state;
  spe_readiness_parameters_t readiness_parameters;
  int errors, tests_run, seed, cyc;
  logic [7:0] exp_q[$];
  // open drain select with pull-up; miso floats when not driven
  assign slave_select_n_i = sel_n & ~(slave_select_n_oe & ~slave_select_n_o);
  assign miso_w = spi_miso_oe ? spi_miso_o : 1'bz;
  spe_endpoint #(.POT_CYC(8), .MAX_CLK_KHZ(MAX_KHZ)) u_spe_endpoint (
    .ref_clk(ref_clk), .rst_n(rst_n), .spi_clk(spi_clk),
    .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o), .spi_miso_oe(spi_miso_oe),
    .slave_select_n_i(slave_select_n_i), .slave_select_n_o(slave_select_n_o),
    .slave_select_n_oe(slave_select_n_oe), .spi_int_o(spi_int_o),
    .four_wire(four_wire), .tx_pending(tx_pending), .tx_data(tx_data),
    .req_sent(req_sent), .busy_req(busy_req), .sleep_req(sleep_req),
    .rx(rx), .slave_state(slave_state),
    .readiness_parameters(readiness_parameters)
  );
  spe_master_model u_spe_master_model (
    .spi_clk(spi_clk), .spi_mosi(spi_mosi), .sel_n(sel_n), .spi_miso(miso_w)
  );
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wait_state(input spe_state_t s);
    int n;
    n = 0;
    while (slave_state !== s && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    `SPE_CHK("state", s, slave_state)
  endtask
  // keep: send the byte already on tx_data, latched before the link froze
  task automatic xfer(input int w, input bit keep);
    logic [15:0] mo, mi;
    logic [7:0] td;
    mo = 16'($random(seed));
    td = keep ? tx_data : 8'($random(seed));
    @(negedge ref_clk);
    tx_data = td;
    exp_q.push_back(mo[15:8]);
    exp_q.push_back(mo[7:0]);
    u_spe_master_model.frame(mo, w, mi);
    `SPE_CHK("miso", {td, td}, mi)
    repeat (8) @(negedge ref_clk);
  endtask
  always @(negedge ref_clk) begin
    if (rx.valid === 1'b1) begin
      exp_b = exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx;
      `SPE_CHK("rx", exp_b, rx.data)
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    {rst_n, tx_pending, tx_data, busy_req, sleep_req} = '0;
    four_wire = 1'b1;
    seed = 50851;
    repeat (8) @(negedge ref_clk);
    `SPE_CHK("state", ST_INIT, slave_state)
    rst_n = 1'b1;
    wait_state(ST_DESEL);
    `SPE_CHK("ready", RDY, readiness_parameters)
    $display("test reset done");
    xfer(READY_TIME_NS, 1'b0);
    xfer(READY_TIME_NS, 1'b0);
    u_spe_master_model.stray(8);
    `SPE_CHK("oe", 1'b0, spi_miso_oe)
    $display("test frame done");
    tx_pending = 1'b1;
    wait_state(ST_PROACT);
    u_spe_master_model.stray(4);
    @(negedge ref_clk);
    `SPE_CHK("line", 1'b0, slave_select_n_i)
    `SPE_CHK("oe", 1'b0, spi_miso_oe)
    wait_state(ST_DESEL);
    tx_pending = 1'b0;
    $display("test request4 done");
    four_wire = 1'b0;
    tx_data = 8'($random(seed));
    tx_pending = 1'b1;
    wait_state(ST_PROACT);
    @(negedge ref_clk);
    `SPE_CHK("int", 1'b1, spi_int_o)
    fork
      xfer(READY_TIME_NS, 1'b1);
      begin
        wait_state(ST_SEL);
        tx_pending = 1'b0;
      end
    join
    sleep_req = 1'b1;
    wait_state(ST_SLEEP);
    sleep_req = 1'b0;
    xfer(RESUME_TIME_NS, 1'b0);
    $display("test request5 sleep done");
    four_wire = 1'b1;
    busy_req = 1'b1;
    fork
      u_spe_master_model.frame(16'h5a5a, READY_TIME_NS, mi_b);
      begin
        wait_state(ST_BUSY);
        @(negedge ref_clk);
        `SPE_CHK("ss_oe", 1'b1, slave_select_n_oe)
      end
    join
    @(negedge ref_clk);
    `SPE_CHK("line", 1'b0, slave_select_n_i)
    busy_req = 1'b0;
    wait_state(ST_DESEL);
    $display("test busy done");
    tx_pending = 1'b1;
    wait_state(ST_PROACT);
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b0;
    tx_pending = 1'b0;
    repeat (3) @(negedge ref_clk);
    `SPE_CHK("state", ST_INIT, slave_state)
    `SPE_CHK("ss_oe", 1'b0, slave_select_n_oe)
    rst_n = 1'b1;
    wait_state(ST_DESEL);
    $display("test reset again done");
    `SPE_CHK("left", 0, exp_q.size())
    print_verdict();
  end
endmodule
`default_nettype wire
